// >>> src/sfcf_regs.vh
// Opcodes, status fields, protect bounds and timing counts
`ifndef SFCF_REGS_VH
`define SFCF_REGS_VH
`define SFCF_OP_WREN 8'h06
`define SFCF_OP_WRDI 8'h04
`define SFCF_OP_RDSR 8'h05
`define SFCF_OP_WRSR 8'h01
`define SFCF_OP_READ 8'h03
`define SFCF_OP_FREAD 8'h0b
`define SFCF_OP_PP 8'h02
`define SFCF_OP_SE 8'hd8
`define SFCF_OP_CE 8'hc7
`define SFCF_OP_PD 8'hb9
`define SFCF_OP_RPP 8'h53
`define SFCF_OP_FRPP 8'h5b
`define SFCF_OP_PPP 8'h52
`define SFCF_OP_EPP 8'hd5
`define SFCF_OP_RPD 8'hab
`define SFCF_OP_MID 8'h90
`define SFCF_OP_JID 8'h9f
`define SFCF_SR_BUSY 0
`define SFCF_SR_WEL 1
`define SFCF_SR_BP_LO 2
`define SFCF_SR_BP_HI 4
`define SFCF_SR_LOCK 7
`define SFCF_SR_WMASK 8'h9c
`define SFCF_END_16M 24'h1fffff
`define SFCF_END_8M 24'h0fffff
`define SFCF_B16_1 24'h1f0000
`define SFCF_B16_2 24'h1e0000
`define SFCF_B16_3 24'h1c0000
`define SFCF_B16_4 24'h180000
`define SFCF_B16_5 24'h100000
`define SFCF_B8_1 24'h0f0000
`define SFCF_B8_2 24'h0e0000
`define SFCF_B8_3 24'h0c0000
`define SFCF_B8_4 24'h080000
`define SFCF_PAGE_BYTES 256
`define SFCF_BUSY_NS 1000
`define SFCF_CLK_NS 10
`define SFCF_BUSY_CYC (`SFCF_BUSY_NS / `SFCF_CLK_NS)
`endif

// >>> src/sfcf_buf2.v
// Two-entry valid/ready buffer
`timescale 1ns/1ns
`default_nettype none
module sfcf_buf2 #(
  parameter W = 8
) (
  input wire clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:1];
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];
  always @(posedge clk) begin
    if (!rstn) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
    end
  end
endmodule // sfcf_buf2
`default_nettype wire

// >>> src/sfcf_front_end.v
// SPI serial flash instruction front end
`timescale 1ns/1ns
`default_nettype none
`include "sfcf_regs.vh"
// What this block does
// - 16M protect ranges per protect level bits
// - 8M protect ranges per protect level bits
// - Full-array protection also locks parameter page
// - Chip select fall starts opcode byte
// - Sample serial_in on rising edge, MSB first
// - Chip select rise completes the instruction
// - Reads may end after any bit
// - Writes need whole bytes else abort
// - While busy only status read accepted
// - Status read repeats status byte
// - Read 03h, three address bytes, stream data
// - Fast read adds one dummy byte
// - Page program even address, even nonzero byte count
// - Parameter page reads 53h/5Bh stream data
// - ABh wakes, repeats device code
// - 90h and 9Fh return identification bytes
// - 06h sets, 04h clears write enable latch
// - Status write alters only bits 7,4,3,2
// - Power-down ignores all but release
// - Lock bit with wp low blocks status write
module sfcf_front_end #(
  parameter IS_16M = 1'b1,
  parameter [7:0] MAKER_CODE = 8'ha5, // Arbitrary identity value
  parameter [7:0] TYPE_CODE = 8'h5a, // Arbitrary identity value
  parameter [7:0] DEV_CODE_8M = 8'h31, // Arbitrary identity value
  parameter [7:0] DEV_CODE_16M = 8'h32, // Arbitrary identity value
  parameter [7:0] CAP_8M = 8'h41, // Arbitrary identity value
  parameter [7:0] CAP_16M = 8'h42, // Arbitrary identity value
  parameter BUSY_CYCLES = `SFCF_BUSY_CYC
) (
  input wire clk,
  input wire rstn,
  input wire spi_clk,
  input wire cs_n,
  input wire serial_in,
  input wire wp_n,
  output reg serial_out,
  output reg serial_out_en,
  input wire [7:0] mem_rdata,
  output reg [23:0] byte_address,
  output reg mem_rd,
  output wire prog_valid,
  input wire prog_ready,
  output wire [7:0] prog_data,
  output reg [23:0] prog_addr,
  output reg prog_param,
  output reg prog_start,
  output reg erase_sector,
  output reg erase_chip,
  output reg erase_param,
  output reg [23:0] erase_addr,
  output reg write_enable_latch,
  output reg status_lock_bit,
  output reg protect_level_hi,
  output reg protect_level_mid,
  output reg protect_level_lo,
  output reg busy,
  output reg power_down,
  output reg aborted
);
  localparam ST_IDLE = 3'd0;
  localparam ST_OP = 3'd1;
  localparam ST_HDR = 3'd2;
  localparam ST_OUT = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_IGNORE = 3'd5;
  // Three-stage pin synchronisers
  reg [2:0] sck_s;
  reg [2:0] cs_s;
  reg [2:0] din_s;
  reg [2:0] wp_s;
  reg sck_st;
  reg cs_st;
  always @(posedge clk) begin
    if (!rstn) begin
      sck_s <= 3'b000;
      cs_s <= 3'b111;
      din_s <= 3'b000;
      wp_s <= 3'b111;
      sck_st <= 1'b0;
      cs_st <= 1'b1;
    end else begin
      sck_s <= {sck_s[1:0], spi_clk};
      cs_s <= {cs_s[1:0], cs_n};
      din_s <= {din_s[1:0], serial_in};
      wp_s <= {wp_s[1:0], wp_n};
      if (sck_s[1] == sck_s[2])
        sck_st <= sck_s[2];
      if (cs_s[1] == cs_s[2])
        cs_st <= cs_s[2];
    end
  end
  wire sck_agree = (sck_s[1] == sck_s[2]);
  wire sck_rise = sck_agree && sck_s[2] && !sck_st;
  wire sck_fall = sck_agree && !sck_s[2] && sck_st;
  wire cs_agree = (cs_s[1] == cs_s[2]);
  wire cs_fall = cs_agree && !cs_s[2] && cs_st;
  wire cs_rise = cs_agree && cs_s[2] && !cs_st;
  wire din = din_s[2];
  wire wp_hi = wp_s[2];
  // Protected range decode
  wire [2:0] bp = {protect_level_hi, protect_level_mid, protect_level_lo};
  reg [23:0] prot_base;
  reg prot_none;
  reg prot_all;
  always @* begin
    prot_none = (bp == 3'b000);
    prot_all = 1'b0;
    prot_base = 24'h000000;
    if (IS_16M) begin
      case (bp)
        3'b001: prot_base = `SFCF_B16_1;
        3'b010: prot_base = `SFCF_B16_2;
        3'b011: prot_base = `SFCF_B16_3;
        3'b100: prot_base = `SFCF_B16_4;
        3'b101: prot_base = `SFCF_B16_5;
        3'b110, 3'b111: prot_all = 1'b1;
        default: prot_base = 24'h000000;
      endcase
    end else begin
      case (bp)
        3'b001: prot_base = `SFCF_B8_1;
        3'b010: prot_base = `SFCF_B8_2;
        3'b011: prot_base = `SFCF_B8_3;
        3'b100: prot_base = `SFCF_B8_4;
        3'b101, 3'b110, 3'b111: prot_all = 1'b1;
        default: prot_base = 24'h000000;
      endcase
    end
  end
  wire [23:0] top_addr = IS_16M ? `SFCF_END_16M : `SFCF_END_8M;
  function is_prot;
    input [23:0] a;
    begin
      is_prot = !prot_none && (prot_all || (a >= prot_base && a <= top_addr));
    end
  endfunction
  wire [7:0] status = {status_lock_bit, 2'b00, protect_level_hi,
    protect_level_mid, protect_level_lo, write_enable_latch, busy};
  // Instruction engine
  reg [2:0] state;
  reg [7:0] shreg;
  reg [2:0] bitcnt;
  reg [7:0] opcode;
  reg [2:0] hdr_left;
  reg [1:0] id_idx;
  reg [7:0] out_byte;
  reg [2:0] out_bit;
  reg [7:0] wrsr_byte;
  reg wrsr_got;
  reg [8:0] pp_count;
  reg [23:0] hdr_addr;
  reg [15:0] busy_cnt;
  reg buf_in_valid;
  reg [7:0] buf_in_data;
  wire buf_in_ready;
  wire [7:0] next_shreg = {shreg[6:0], din};
  wire byte_done = sck_rise && (bitcnt == 3'd7);
  wire dev_code_sel = IS_16M;
  wire [7:0] dev_code = dev_code_sel ? DEV_CODE_16M : DEV_CODE_8M;
  wire [7:0] cap_code = dev_code_sel ? CAP_16M : CAP_8M;
  function [2:0] hdr_len;
    input [7:0] op;
    begin
      case (op)
        `SFCF_OP_READ, `SFCF_OP_PP, `SFCF_OP_SE,
        `SFCF_OP_RPP, `SFCF_OP_PPP, `SFCF_OP_RPD,
        `SFCF_OP_MID: hdr_len = 3'd3;
        `SFCF_OP_FREAD, `SFCF_OP_FRPP: hdr_len = 3'd4;
        `SFCF_OP_WRSR: hdr_len = 3'd1;
        default: hdr_len = 3'd0;
      endcase
    end
  endfunction
  // Byte to drive next on the output for the current read opcode
  reg [7:0] next_out;
  always @* begin
    case (opcode)
      `SFCF_OP_RDSR: next_out = status;
      `SFCF_OP_RPD: next_out = dev_code;
      `SFCF_OP_MID: next_out = (id_idx == 2'd0) ? MAKER_CODE : dev_code;
      `SFCF_OP_JID: next_out = (id_idx == 2'd0) ? MAKER_CODE :
        (id_idx == 2'd1) ? TYPE_CODE : cap_code;
      default: next_out = mem_rdata;
    endcase
  end
  wire is_write_op = (opcode == `SFCF_OP_WREN) || (opcode == `SFCF_OP_WRDI)
    || (opcode == `SFCF_OP_WRSR) || (opcode == `SFCF_OP_PP)
    || (opcode == `SFCF_OP_SE) || (opcode == `SFCF_OP_CE)
    || (opcode == `SFCF_OP_PD) || (opcode == `SFCF_OP_PPP)
    || (opcode == `SFCF_OP_EPP);
  wire wrsr_allowed = !(status_lock_bit && !wp_hi);
  wire param_locked = prot_all;
  always @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'd0;
      opcode <= 8'h00;
      hdr_left <= 3'd0;
      id_idx <= 2'd0;
      out_byte <= 8'h00;
      out_bit <= 3'd0;
      wrsr_byte <= 8'h00;
      wrsr_got <= 1'b0;
      pp_count <= 9'h000;
      hdr_addr <= 24'h000000;
      busy_cnt <= 16'h0000;
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
      byte_address <= 24'h000000;
      mem_rd <= 1'b0;
      prog_addr <= 24'h000000;
      prog_param <= 1'b0;
      prog_start <= 1'b0;
      erase_sector <= 1'b0;
      erase_chip <= 1'b0;
      erase_param <= 1'b0;
      erase_addr <= 24'h000000;
      write_enable_latch <= 1'b0;
      status_lock_bit <= 1'b0;
      protect_level_hi <= 1'b0;
      protect_level_mid <= 1'b0;
      protect_level_lo <= 1'b0;
      busy <= 1'b0;
      power_down <= 1'b0;
      aborted <= 1'b0;
      buf_in_valid <= 1'b0;
      buf_in_data <= 8'h00;
    end else begin
      mem_rd <= 1'b0;
      prog_start <= 1'b0;
      erase_sector <= 1'b0;
      erase_chip <= 1'b0;
      erase_param <= 1'b0;
      aborted <= 1'b0;
      if (buf_in_valid && buf_in_ready)
        buf_in_valid <= 1'b0;
      // Internal cycle timer, clears the write enable latch when done
      if (busy) begin
        if (busy_cnt == 16'h0000) begin
          busy <= 1'b0;
          write_enable_latch <= 1'b0;
        end else
          busy_cnt <= busy_cnt - 16'h0001;
      end
      if (sck_rise && state != ST_IDLE) begin
        shreg <= next_shreg;
        bitcnt <= bitcnt + 3'd1;
      end
      if (cs_fall) begin
        state <= ST_OP;
        bitcnt <= 3'd0;
        wrsr_got <= 1'b0;
        pp_count <= 9'h000;
        id_idx <= 2'd0;
      end else if (cs_rise) begin
        state <= ST_IDLE;
        serial_out_en <= 1'b0;
        // A frame cut inside the opcode byte must not replay the last opcode
        if (is_write_op && state != ST_IGNORE && state != ST_OUT
            && state != ST_OP && state != ST_IDLE) begin
          if (bitcnt != 3'd0)
            aborted <= 1'b1;
          else if (opcode == `SFCF_OP_WREN)
            write_enable_latch <= 1'b1;
          else if (opcode == `SFCF_OP_WRDI)
            write_enable_latch <= 1'b0;
          else if (opcode == `SFCF_OP_PD)
            power_down <= 1'b1;
          else if (write_enable_latch) begin
            if (opcode == `SFCF_OP_WRSR && wrsr_got && wrsr_allowed) begin
              status_lock_bit <= wrsr_byte[`SFCF_SR_LOCK];
              {protect_level_hi, protect_level_mid, protect_level_lo}
                <= wrsr_byte[`SFCF_SR_BP_HI:`SFCF_SR_BP_LO];
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES[15:0];
            end else if (opcode == `SFCF_OP_SE && state == ST_WDATA
                && !is_prot(hdr_addr)) begin
              erase_sector <= 1'b1;
              erase_addr <= hdr_addr;
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES[15:0];
            end else if (opcode == `SFCF_OP_CE && prot_none) begin
              erase_chip <= 1'b1;
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES[15:0];
            end else if (opcode == `SFCF_OP_EPP && !param_locked) begin
              erase_param <= 1'b1;
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES[15:0];
            end else if ((opcode == `SFCF_OP_PP || opcode == `SFCF_OP_PPP)
                && pp_count != 9'h000 && !pp_count[0] && !prog_addr[0]
                && (prog_param ? !param_locked : !is_prot(prog_addr))) begin
              prog_start <= 1'b1;
              busy <= 1'b1;
              busy_cnt <= BUSY_CYCLES[15:0];
            end
          end
        end
      end else begin
        case (state)
          ST_OP: begin
            if (byte_done) begin
              opcode <= next_shreg;
              hdr_left <= hdr_len(next_shreg);
              hdr_addr <= 24'h000000;
              if (power_down && next_shreg != `SFCF_OP_RPD)
                state <= ST_IGNORE;
              else if (busy && next_shreg != `SFCF_OP_RDSR)
                state <= ST_IGNORE;
              else if (next_shreg == `SFCF_OP_RDSR
                  || next_shreg == `SFCF_OP_JID) begin
                state <= ST_OUT;
                out_bit <= 3'd0;
                out_byte <= (next_shreg == `SFCF_OP_RDSR) ? status
                  : MAKER_CODE;
                id_idx <= 2'd0;
              end else if (hdr_len(next_shreg) != 3'd0)
                state <= ST_HDR;
              else
                state <= ST_WDATA;
            end
          end
          ST_HDR: begin
            if (byte_done) begin
              hdr_left <= hdr_left - 3'd1;
              if (opcode == `SFCF_OP_WRSR) begin
                wrsr_byte <= next_shreg & `SFCF_SR_WMASK;
                wrsr_got <= 1'b1;
                state <= ST_WDATA;
              end else begin
                // The dummy byte of the fast reads stays out of the address
                if (hdr_left != 3'd1 || hdr_len(opcode) != 3'd4)
                  hdr_addr <= {hdr_addr[15:0], next_shreg};
                if (hdr_left == 3'd1) begin
                  if (opcode == `SFCF_OP_PP || opcode == `SFCF_OP_PPP) begin
                    state <= ST_WDATA;
                    prog_addr <= {(opcode == `SFCF_OP_PPP) ? 16'h0000
                      : hdr_addr[15:0], next_shreg};
                    prog_param <= (opcode == `SFCF_OP_PPP);
                  end else if (opcode == `SFCF_OP_SE)
                    state <= ST_WDATA;
                  else begin
                    state <= ST_OUT;
                    out_bit <= 3'd0;
                    power_down <= 1'b0;
                    if (opcode == `SFCF_OP_READ)
                      byte_address <= {hdr_addr[15:0], next_shreg};
                    else if (opcode == `SFCF_OP_FREAD)
                      byte_address <= hdr_addr;
                    else if (opcode == `SFCF_OP_RPP)
                      byte_address <= {16'h0000, next_shreg};
                    else if (opcode == `SFCF_OP_FRPP)
                      byte_address <= {16'h0000, hdr_addr[7:0]};
                    mem_rd <= 1'b1;
                    id_idx <= 2'd0;
                  end
                end
              end
            end
          end
          ST_OUT: begin
            // Load each byte once its fetch has returned
            if (mem_rd)
              out_byte <= next_out;
            if (sck_fall) begin
              serial_out_en <= 1'b1;
              serial_out <= out_byte[3'd7 - out_bit];
              out_bit <= out_bit + 3'd1;
              if (out_bit == 3'd7) begin
                id_idx <= (id_idx == 2'd2) ? 2'd2 : id_idx + 2'd1;
                byte_address <= byte_address + 24'h000001;
                mem_rd <= 1'b1;
              end
            end
          end
          ST_WDATA: begin
            if (byte_done && (opcode == `SFCF_OP_PP
                || opcode == `SFCF_OP_PPP)) begin
              if (!prog_addr[0] && (opcode == `SFCF_OP_PPP ? !param_locked
                  : !is_prot(prog_addr)) && write_enable_latch) begin
                buf_in_valid <= 1'b1;
                buf_in_data <= next_shreg;
              end
              pp_count <= pp_count + 9'h001;
            end
          end
          default: state <= state;
        endcase
      end
    end
  end
  sfcf_buf2 #(
    .W(8)
  ) u_prog_buf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_data)
  );
endmodule // sfcf_front_end
`default_nettype wire

// >>> verif/sfcf_host.sv
// SPI host model driving the flash front end in mode 0
`timescale 1ns/1ns
`default_nettype none
module sfcf_host #(
  parameter HALF = 8
) (
  input wire logic clk,
  input wire logic serial_out,
  output logic spi_clk,
  output logic cs_n,
  output logic serial_in
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Select falls while the serial clock is parked low
  task automatic go();
    hw(1);
    cs_n = 1'b0;
    hw(HALF);
  endtask
  // Data set while low, reply taken just before the rising edge
  task automatic bit1(input logic d, output logic r);
    serial_in = d;
    hw(HALF);
    r = serial_out;
    spi_clk = 1'b1;
    hw(HALF);
    spi_clk = 1'b0;
  endtask
  task automatic xb(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit1(t[i], r[i]);
  endtask
  // Released data line shows the inverse of its last level
  task automatic stop();
    hw(HALF);
    cs_n = 1'b1;
    serial_in = ~serial_in;
    hw(3 * HALF);
  endtask
endmodule // sfcf_host
`default_nettype wire

// >>> verif/sfcf_chk.sv
// Concurrent checks on the flash front end ports
`timescale 1ns/1ns
`default_nettype none
module sfcf_chk #(
  parameter IS_16M = 1'b1,
  parameter BUSY_CYCLES = 100
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic serial_out_en,
  input wire logic [23:0] prog_addr,
  input wire logic prog_param,
  input wire logic prog_start,
  input wire logic erase_sector,
  input wire logic erase_chip,
  input wire logic erase_param,
  input wire logic [23:0] erase_addr,
  input wire logic write_enable_latch,
  input wire logic status_lock_bit,
  input wire logic protect_level_hi,
  input wire logic protect_level_mid,
  input wire logic protect_level_lo,
  input wire logic busy,
  input wire logic power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [2:0] bp = {protect_level_hi, protect_level_mid, protect_level_lo};
  wire all_prot = bp[2] & (bp[1] | (!IS_16M & bp[0]));
  wire ops = prog_start | erase_sector | erase_chip | erase_param;
  int bcnt;
  function automatic logic prot(input logic [2:0] b, input logic [23:0] a);
    logic [23:0] lo;
    case (b)
      3'd0: return 1'b0;
      3'd1: lo = IS_16M ? 24'h1f0000 : 24'h0f0000;
      3'd2: lo = IS_16M ? 24'h1e0000 : 24'h0e0000;
      3'd3: lo = IS_16M ? 24'h1c0000 : 24'h0c0000;
      3'd4: lo = IS_16M ? 24'h180000 : 24'h080000;
      3'd5: lo = IS_16M ? 24'h100000 : 24'h000000;
      default: lo = 24'h000000;
    endcase
    return a >= lo;
  endfunction
  always @(posedge clk) begin
    if (!rstn || !busy) bcnt <= 0;
    else bcnt <= bcnt + 1;
  end
  sequence s_cs_idle;
    cs_n [*8];
  endsequence
  sequence s_cs_risen;
    $past(cs_n) && $past(cs_n, 2);
  endsequence
  a_erase_prot: assert property (erase_sector
    |-> !prot(bp, erase_addr))
    else $error("sector erase inside protected range");
  a_param_lock: assert property (erase_param
    || prog_start && prog_param |-> !all_prot)
    else $error("parameter page altered under full protection");
  a_chip_free: assert property (erase_chip |-> bp == 3'b000)
    else $error("chip erase while protected");
  a_prog_even: assert property (prog_start |-> !prog_addr[0])
    else $error("program started on odd address");
  a_ops_at_rise: assert property (ops |-> s_cs_risen)
    else $error("operation fired before select rose");
  a_wel_not_busy: assert property ($rose(write_enable_latch)
    |-> !$past(busy))
    else $error("write enable taken while busy");
  a_wel_not_pd: assert property ($rose(write_enable_latch)
    |-> !$past(power_down))
    else $error("write enable taken in power down");
  a_status_lock: assert property ($changed({status_lock_bit, bp})
    |-> !$past(status_lock_bit) || $past(wp_n))
    else $error("locked status changed");
  a_busy_len: assert property ($fell(busy)
    |-> $past(bcnt) >= BUSY_CYCLES - 2 && $past(bcnt) <= BUSY_CYCLES)
    else $error("busy length wrong");
  a_oe_idle: assert property (s_cs_idle |-> !serial_out_en)
    else $error("output driven while deselected");
endmodule // sfcf_chk
bind sfcf_front_end sfcf_chk #(.IS_16M(IS_16M), .BUSY_CYCLES(BUSY_CYCLES))
  u_sfcf_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .wp_n(wp_n),
  .serial_out_en(serial_out_en), .prog_addr(prog_addr),
  .prog_param(prog_param), .prog_start(prog_start),
  .erase_sector(erase_sector), .erase_chip(erase_chip),
  .erase_param(erase_param), .erase_addr(erase_addr),
  .write_enable_latch(write_enable_latch),
  .status_lock_bit(status_lock_bit), .protect_level_hi(protect_level_hi),
  .protect_level_mid(protect_level_mid), .protect_level_lo(protect_level_lo),
  .busy(busy), .power_down(power_down));
`default_nettype wire

// >>> verif/sfcf_front_end_tb.sv
// Self-checking bench for the flash instruction front end
`timescale 1ns/1ns
`default_nettype none
module sfcf_front_end_tb;
  localparam [7:0] MK = 8'h3c; // Arbitrary identity value
  localparam [7:0] TY = 8'h66; // Arbitrary identity value
  localparam [7:0] CP = 8'h77; // Arbitrary identity value
  localparam [7:0] DV = 8'h29; // Arbitrary identity value
  logic clk, rstn, wp_n, prog_ready, b;
  wire spi_clk, cs_n, serial_in, serial_out, serial_out_en, mem_rd;
  wire prog_valid, prog_param, prog_start, erase_sector, erase_chip;
  wire erase_param, write_enable_latch, status_lock_bit, busy, power_down;
  wire protect_level_hi, protect_level_mid, protect_level_lo, aborted;
  wire [23:0] byte_address, prog_addr, erase_addr;
  wire [7:0] prog_data;
  wire [7:0] mem_rdata = byte_address[7:0] ^ 8'h5a;
  wire [2:0] bpv = {protect_level_hi, protect_level_mid, protect_level_lo};
  int err_total = 0, check_count = 0, cyc = 0, s;
  int n_sec = 0, n_chip = 0, n_par = 0, n_prog = 0, n_ab = 0;
  logic [63:0] rx;
  logic [7:0] r8;
  logic [7:0] got[$];
  logic [23:0] a;
  logic [23:0] lb[8] = '{24'h200000, 24'h1f0000, 24'h1e0000, 24'h1c0000,
    24'h180000, 24'h100000, 24'h0, 24'h0};
  sfcf_front_end #(.MAKER_CODE(MK), .TYPE_CODE(TY), .DEV_CODE_16M(DV),
    .CAP_16M(CP), .BUSY_CYCLES(400)) u_sfcf_front_end (.clk(clk),
    .rstn(rstn), .spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in),
    .wp_n(wp_n), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .mem_rdata(mem_rdata), .byte_address(byte_address), .mem_rd(mem_rd),
    .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_data(prog_data), .prog_addr(prog_addr), .prog_param(prog_param),
    .prog_start(prog_start), .erase_sector(erase_sector),
    .erase_chip(erase_chip), .erase_param(erase_param),
    .erase_addr(erase_addr), .write_enable_latch(write_enable_latch),
    .status_lock_bit(status_lock_bit), .protect_level_hi(protect_level_hi),
    .protect_level_mid(protect_level_mid),
    .protect_level_lo(protect_level_lo), .busy(busy),
    .power_down(power_down), .aborted(aborted));
  sfcf_host u_sfcf_host (.clk(clk), .serial_out(serial_out),
    .spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    n_sec += (erase_sector === 1'b1);
    n_chip += (erase_chip === 1'b1);
    n_par += (erase_param === 1'b1);
    n_prog += (prog_start === 1'b1);
    n_ab += (aborted === 1'b1);
    if (prog_valid === 1'b1 && prog_ready) got.push_back(prog_data);
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One framed instruction of n bytes, replies shift into rx
  task automatic fr(input logic [63:0] tx, input int n);
    u_sfcf_host.go();
    for (int i = n - 1; i >= 0; i--) begin
      u_sfcf_host.xb(tx[8*i +: 8], r8);
      rx = {rx[55:0], r8};
    end
    u_sfcf_host.stop();
  endtask
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 600) begin
      @(negedge clk);
      k++;
    end
    chk(busy, 0);
  endtask
  task automatic op(input logic [63:0] tx, input int n);
    fr(8'h06, 1);
    fr(tx, n);
    idle();
  endtask
  initial begin
    rstn = 1'b0;
    wp_n = 1'b1;
    prog_ready = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (6) @(negedge clk);
    chk({write_enable_latch, busy, power_down, bpv}, 0);
    fr(8'h06, 1);
    chk(write_enable_latch, 1);
    fr(8'h04, 1);
    chk(write_enable_latch, 0);
    // Write enable with a stray ninth bit, then a read cut mid-byte
    s = n_ab;
    u_sfcf_host.go();
    u_sfcf_host.xb(8'h06, r8);
    u_sfcf_host.bit1(1'b0, b);
    u_sfcf_host.stop();
    chk(n_ab - s, 1);
    chk(write_enable_latch, 0);
    u_sfcf_host.go();
    for (int i = 0; i < 4; i++) u_sfcf_host.xb(i == 0 ? 8'h03 : 8'h00, r8);
    repeat (3) u_sfcf_host.bit1(1'b0, b);
    u_sfcf_host.stop();
    chk(n_ab - s, 1);
    // Status write, then traffic while the write cycle runs
    fr(8'h06, 1);
    fr({8'h01, 8'hec}, 2);
    fr(8'h06, 1);
    fr({8'h05, 16'h0}, 3);
    chk(rx[15:8] & 8'hfd, 8'h8d);
    idle();
    fr({8'h05, 16'h0}, 3);
    chk(rx[15:0], 16'h8c8c);
    wp_n = 1'b0;
    op({8'h01, 8'h00}, 2);
    chk({status_lock_bit, bpv}, 4'hb);
    wp_n = 1'b1;
    for (int bp = 0; bp < 8; bp++) begin
      op({8'h01, 3'b0, bp[2:0], 2'b0}, 2);
      chk(bpv, bp[2:0]);
      for (int k = 0; k < 2; k++) begin
        a = (k == 0) ? lb[bp] - 24'h1 : lb[bp];
        if ((k == 0 && lb[bp] == 0) || (k == 1 && bp == 0)) continue;
        s = n_sec;
        op({8'hd8, a}, 4);
        chk(n_sec - s, k == 0);
        if (k == 0) chk(erase_addr, a);
      end
      s = n_par;
      op(8'hd5, 1);
      chk(n_par - s, bp < 6);
      s = n_chip;
      op(8'hc7, 1);
      chk(n_chip - s, bp == 0);
    end
    op({8'h01, 8'h00}, 2);
    for (int f = 0; f < 2; f++) begin
      fr(f ? {8'h0b, 24'h1501fe, 32'h0} : {8'h03, 24'h1501fe, 24'h0},
        f ? 8 : 7);
      chk(rx[23:0], {8'hfe ^ 8'h5a, 8'hff ^ 8'h5a, 8'h00 ^ 8'h5a});
      chk(byte_address, 24'h150201);
    end
    fr({8'h53, 16'h0, 8'h20, 8'h0}, 5);
    chk(rx[7:0], 8'h20 ^ 8'h5a);
    fr({8'h5b, 16'h0, 8'h21, 16'h0}, 6);
    chk(rx[7:0], 8'h21 ^ 8'h5a);
    fr({8'h9f, 24'h0}, 4);
    chk(rx[23:0], {MK, TY, CP});
    fr({8'h90, 40'h0}, 6);
    chk(rx[15:0], {MK, DV});
    fr(8'hb9, 1);
    chk(power_down, 1);
    fr(8'h06, 1);
    chk(write_enable_latch, 0);
    fr({8'hab, 40'h0}, 6);
    chk({power_down, rx[15:0]}, {1'b0, DV, DV});
    // Program with the receiver stalled so the buffer fills
    prog_ready = 1'b0;
    got.delete();
    s = n_prog;
    op({8'h02, 24'h10, 16'h3cc3}, 6);
    chk({prog_valid, prog_param, prog_addr}, {2'b10, 24'h10});
    chk(n_prog - s, 1);
    prog_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk(got.size(), 2);
    chk({got[0], got[1], prog_valid}, {16'h3cc3, 1'b0});
    s = n_prog;
    op({8'h52, 16'h0, 8'h20, 16'h0}, 6);
    chk({prog_param, prog_addr}, {1'b1, 24'h20});
    chk(n_prog - s, 1);
    s = n_prog;
    op({8'h02, 24'h11, 16'h0}, 6);
    chk(n_prog - s, 0);
    print_verdict();
  end
endmodule // sfcf_front_end_tb
`default_nettype wire
